// ---- verilog/core_status_defs.svh ----
// offsets, field positions, reset values and timing counts of the status bank
`ifndef CORE_STATUS_DEFS_SVH
`define CORE_STATUS_DEFS_SVH

// ***********************************
// register numbers
// ***********************************
`define OFFSET_SECURITY_CONFIG 8'h05
`define OFFSET_RING_OSC_CONTROL 8'h06
`define OFFSET_CORE_CELL_OSC_COUNT 8'h07
`define OFFSET_CORE_WIRE_OSC_COUNT 8'h08
`define OFFSET_PERIPH_CELL_OSC_COUNT 8'h09
`define OFFSET_PERIPH_WIRE_OSC_COUNT 8'h0a
`define OFFSET_MEMORY_SIZE 8'h0c
`define OFFSET_SAVED_STATUS_WORD 8'h10
`define OFFSET_SAVED_PROGRAM_COUNTER 8'h11
`define OFFSET_SAVED_STACK_POINTER 8'h12
`define OFFSET_DEBUG_FETCH_THREAD_SELECT 8'h13
`define OFFSET_DEBUG_FETCH_REGISTER_SELECT 8'h14

// ***********************************
// security configuration fields
// ***********************************
`define SEC_WRITE_LOCK_BIT 31
`define SEC_GLOBAL_DEBUG_DISABLE_BIT 14
`define SEC_LOCK_ALL_SECTORS_BIT 12
`define SEC_SECTOR_LOCK_LSB 8
`define SEC_SECTOR_COUNT 4
`define SEC_REDUNDANCY_ENABLE_BIT 7
`define SEC_BOOT_FROM_OTP_BIT 5
`define SEC_JTAG_CONFIG_DENY_BIT 4
`define SEC_JTAG_TAP_DISABLE_BIT 0
`define SEC_WRITABLE_MASK 32'h8000_5fb1
`define SEC_RESET_VALUE 32'h0000_0000

// ***********************************
// ring oscillator control fields
// ***********************************
`define OSC_CORE_ENABLE_BIT 1
`define OSC_PERIPH_ENABLE_BIT 0
`define OSC_SETTLED_BIT 2
`define OSC_CONTROL_RESET_VALUE 2'b00
`define OSC_COUNT_WIDTH 16
`define OSC_SETTLE_CYCLES 10

// ***********************************
// debug fields and memory size mask
// ***********************************
`define STATUS_WORD_WIDTH 11
`define STATUS_WORD_WRITABLE_MASK 11'h6df
`define DEBUG_THREAD_SELECT_WIDTH 8
`define DEBUG_REGISTER_SELECT_WIDTH 5
`define MEMORY_SIZE_LOW_MASK 32'hffff_fffc

`endif

// ---- verilog/core_status_pkg.sv ----
// types shared by the status bank
package core_status_pkg;
	typedef logic [7:0] status_addr_type;
	typedef logic [31:0] word_type;
	typedef enum {
		osc_core_cell,
		osc_core_wire,
		osc_periph_cell,
		osc_periph_wire
	} osc_index_type;
	typedef enum {
		osc_running,
		osc_stopping,
		osc_settled
	} osc_phase_type;
endpackage

// ---- verilog/ring_osc_counter.sv ----
// counter of one free-running ring oscillator, resynchronised to the core clock
`timescale 1ns/10ps
`default_nettype none
module ring_osc_counter #(
	parameter int WIDTH = 16
) (
	input wire logic clock,
	input wire logic clock_enable,
	input wire logic rst_n,
	input wire logic osc_in,
	input wire logic count_enable,
	output logic [WIDTH-1:0] count
);
	logic sync_first;
	logic sync_second;
	logic sync_third;
	logic [WIDTH-1:0] tally = '0;

	// ***********************************
	// three-stage capture of the oscillator
	// ***********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_first <= 1'b0;
			sync_second <= 1'b0;
			sync_third <= 1'b0;
		end else if (clock_enable) begin
			sync_first <= osc_in;
			sync_second <= sync_first;
			sync_third <= sync_second;
		end
	end

	// ***********************************
	// count of rising edges
	// ***********************************
	// no reset on purpose: the count survives a system reset
	always_ff @(posedge clock) begin
		if (clock_enable && count_enable && sync_second && !sync_third) begin
			tally <= tally + WIDTH'(1);
		end
	end
	assign count = tally;
endmodule
`default_nettype wire

// ---- verilog/core_status_security_debug_regs.sv ----
// processor status bank: security word, ring oscillators, memory size, debug capture
// Function
// RQ1 - security register holds word loaded from otp
// RQ2 - bit 31 removes write permission
// RQ3 - bit 14 blocks global debug facility
// RQ4 - bits 11:8 lock sectors; bit 12 all
// RQ5 - bit 5 forces boot from otp
// RQ6 - bit 4 denies jtag config access
// RQ7 - bit 0 disables jtag debug tap
// RQ8 - four oscillators, counters, control register starts/stops
// RQ9 - core and peripheral enable bits reset zero
// RQ10 - software reads counts ten cycles after stop
// RQ11 - oscillators asynchronous, counts give random bits
// RQ12 - sixteen-bit read-only counts survive system reset
// RQ13 - counts at 0x07-0x0a in fixed order
// RQ14 - memory size in bytes, bits 31:2
// RQ15 - debug entry captures saved status word
// RQ16 - status bits 7 fast, 6 paused
// RQ17 - status bits 4 kernel, 3 interrupt, 2 event
// RQ18 - bits 1 interrupts, 0 events, 10 address space
// RQ19 - debug entry captures saved program counter
// RQ20 - debug entry captures saved stack pointer
// RQ21 - fetch thread select, eight bits 7:0
// RQ22 - fetch register select, five bits 4:0
// RQ23 - status reads and writes by register number
// RQ24 - debug fields writable only in debug mode
// RQ25 - locked security ignores writes until reset
`timescale 1ns/10ps
`default_nettype none
`include "core_status_defs.svh"
module core_status_security_debug_regs #(
	parameter logic [31:0] MEMORY_BYTES = 32'h0004_0000,
	parameter int OSC_WIDTH = `OSC_COUNT_WIDTH
) (
	input wire logic clock,
	input wire logic clock_enable,
	input wire logic rst_n,
	input wire logic status_read,
	input wire logic status_write,
	input wire core_status_pkg::status_addr_type status_addr,
	input wire core_status_pkg::word_type status_wdata,
	output core_status_pkg::word_type status_rdata,
	output logic status_rvalid,
	output logic status_unmapped,
	input wire logic otp_word_valid,
	input wire core_status_pkg::word_type otp_security_word,
	output logic global_debug_disable,
	output logic [`SEC_SECTOR_COUNT-1:0] otp_sector_lock,
	output logic otp_redundancy_enable,
	output logic boot_from_otp,
	output logic jtag_config_access_deny,
	output logic jtag_tap_disable,
	output logic core_osc_enable,
	output logic periph_osc_enable,
	input wire logic [3:0] ring_osc_in,
	input wire logic debug_mode,
	input wire logic debug_entry,
	input wire logic [`STATUS_WORD_WIDTH-1:0] thread_status_word,
	input wire core_status_pkg::word_type thread_program_counter,
	input wire core_status_pkg::word_type thread_stack_pointer,
	output logic [`DEBUG_THREAD_SELECT_WIDTH-1:0] debug_fetch_thread,
	output logic [`DEBUG_REGISTER_SELECT_WIDTH-1:0] debug_fetch_register
);
	// ***********************************
	// declarations
	// ***********************************
	logic rst_meta_n;
	logic rst_sync_n;
	core_status_pkg::word_type security_config;
	logic security_loaded;
	logic [1:0] ring_osc_control;
	core_status_pkg::osc_phase_type osc_phase;
	core_status_pkg::osc_phase_type next_osc_phase;
	logic [3:0] settle_count;
	logic [OSC_WIDTH-1:0] osc_count [0:3];
	logic [3:0] osc_count_enable;
	logic [`STATUS_WORD_WIDTH-1:0] saved_status_word;
	core_status_pkg::word_type saved_program_counter;
	core_status_pkg::word_type saved_stack_pointer;
	logic [`DEBUG_THREAD_SELECT_WIDTH-1:0] debug_fetch_thread_select;
	logic [`DEBUG_REGISTER_SELECT_WIDTH-1:0] debug_fetch_register_select;
	logic write_active;
	logic debug_write_active;
	core_status_pkg::word_type next_rdata;
	logic next_unmapped;

	// ***********************************
	// decode helpers
	// ***********************************
	function automatic logic hits(
		input core_status_pkg::status_addr_type addr,
		input core_status_pkg::status_addr_type offset
	);
		hits = (addr == offset);
	endfunction

	function automatic logic is_debug_field(input core_status_pkg::status_addr_type addr);
		is_debug_field = hits(addr, `OFFSET_SAVED_STATUS_WORD)
			|| hits(addr, `OFFSET_SAVED_PROGRAM_COUNTER)
			|| hits(addr, `OFFSET_SAVED_STACK_POINTER)
			|| hits(addr, `OFFSET_DEBUG_FETCH_THREAD_SELECT)
			|| hits(addr, `OFFSET_DEBUG_FETCH_REGISTER_SELECT);
	endfunction

	function automatic logic [OSC_WIDTH-1:0] pick_count(input logic [1:0] index,
		input logic [OSC_WIDTH-1:0] c0, input logic [OSC_WIDTH-1:0] c1,
		input logic [OSC_WIDTH-1:0] c2, input logic [OSC_WIDTH-1:0] c3);
		case (index)
			2'h0: pick_count = c0;
			2'h1: pick_count = c1;
			2'h2: pick_count = c2;
			default: pick_count = c3;
		endcase
	endfunction

	// ***********************************
	// reset release
	// ***********************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ***********************************
	// access strobes
	// ***********************************
	assign write_active = clock_enable && status_write; // RQ23
	// debug fields ignore writes outside debug mode
	assign debug_write_active = write_active && debug_mode; // RQ24

	// ***********************************
	// security configuration
	// ***********************************
	// the otp load arrives once per reset; later loads are ignored so that
	// a lock set by software cannot be undone by a stray strobe
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			security_config <= `SEC_RESET_VALUE;
			security_loaded <= 1'b0;
		end else if (clock_enable) begin
			if (otp_word_valid && !security_loaded) begin
				security_config <= otp_security_word & `SEC_WRITABLE_MASK; // RQ1
				security_loaded <= 1'b1;
			end else if (write_active
				&& hits(status_addr, `OFFSET_SECURITY_CONFIG)
				&& !security_config[`SEC_WRITE_LOCK_BIT]) begin // RQ2 RQ25
				security_config <= status_wdata & `SEC_WRITABLE_MASK;
			end
		end
	end

	assign global_debug_disable = security_config[`SEC_GLOBAL_DEBUG_DISABLE_BIT]; // RQ3
	assign otp_redundancy_enable = security_config[`SEC_REDUNDANCY_ENABLE_BIT];
	assign boot_from_otp = security_config[`SEC_BOOT_FROM_OTP_BIT]; // RQ5
	assign jtag_config_access_deny = security_config[`SEC_JTAG_CONFIG_DENY_BIT]; // RQ6
	assign jtag_tap_disable = security_config[`SEC_JTAG_TAP_DISABLE_BIT]; // RQ7

	genvar sector;
	generate
		for (sector = 0; sector < `SEC_SECTOR_COUNT; sector++) begin : g_sector
			assign otp_sector_lock[sector] =
				security_config[`SEC_SECTOR_LOCK_LSB + sector]
				|| security_config[`SEC_LOCK_ALL_SECTORS_BIT]; // RQ4
		end
	endgenerate

	// ***********************************
	// ring oscillator control
	// ***********************************
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ring_osc_control <= `OSC_CONTROL_RESET_VALUE; // RQ9
		end else if (write_active && hits(status_addr, `OFFSET_RING_OSC_CONTROL)) begin
			ring_osc_control[1] <= status_wdata[`OSC_CORE_ENABLE_BIT]; // RQ8
			ring_osc_control[0] <= status_wdata[`OSC_PERIPH_ENABLE_BIT]; // RQ8
		end
	end

	assign core_osc_enable = ring_osc_control[1];
	assign periph_osc_enable = ring_osc_control[0];

	// ***********************************
	// settle tracking after a stop
	// ***********************************
	// software must wait before reading; this phase is readable so that a
	// driver can poll instead of counting instructions
	always_comb begin
		next_osc_phase = osc_phase;
		case (osc_phase)
			core_status_pkg::osc_running: begin
				if (ring_osc_control == 2'b00) begin
					next_osc_phase = core_status_pkg::osc_stopping;
				end
			end
			core_status_pkg::osc_stopping: begin
				if (ring_osc_control != 2'b00) begin
					next_osc_phase = core_status_pkg::osc_running;
				end else if (settle_count == 4'(`OSC_SETTLE_CYCLES - 1)) begin
					next_osc_phase = core_status_pkg::osc_settled; // RQ10
				end
			end
			core_status_pkg::osc_settled: begin
				if (ring_osc_control != 2'b00) begin
					next_osc_phase = core_status_pkg::osc_running;
				end
			end
			default: next_osc_phase = core_status_pkg::osc_running;
		endcase
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			osc_phase <= core_status_pkg::osc_settled;
		end else if (clock_enable) begin
			osc_phase <= next_osc_phase;
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			settle_count <= 4'h0;
		end else if (clock_enable) begin
			if (osc_phase == core_status_pkg::osc_stopping) begin
				settle_count <= settle_count + 4'h1;
			end else begin
				settle_count <= 4'h0;
			end
		end
	end

	// ***********************************
	// oscillator counters
	// ***********************************
	// the oscillators run on their own; each edge is resampled here, which
	// caps the countable rate near half of the core clock
	assign osc_count_enable = {
		periph_osc_enable, periph_osc_enable,
		core_osc_enable, core_osc_enable
	};

	genvar osc;
	generate
		for (osc = 0; osc < 4; osc++) begin : g_osc
			ring_osc_counter #(
				.WIDTH(OSC_WIDTH)
			) counter (
				.clock(clock),
				.clock_enable(clock_enable),
				.rst_n(rst_sync_n),
				.osc_in(ring_osc_in[osc]),
				.count_enable(osc_count_enable[osc]),
				.count(osc_count[osc])
			); // RQ11 RQ12
		end
	endgenerate

	// ***********************************
	// debug capture
	// ***********************************
	// capture on debug entry wins over a write in the same cycle
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			saved_status_word <= '0;
		end else if (clock_enable && debug_entry) begin
			saved_status_word <= thread_status_word; // RQ15 RQ16 RQ17 RQ18
		end else if (debug_write_active
			&& hits(status_addr, `OFFSET_SAVED_STATUS_WORD)) begin
			saved_status_word <= (saved_status_word & ~`STATUS_WORD_WRITABLE_MASK)
				| (status_wdata[`STATUS_WORD_WIDTH-1:0]
				& `STATUS_WORD_WRITABLE_MASK); // RQ24
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			saved_program_counter <= '0;
		end else if (clock_enable && debug_entry) begin
			saved_program_counter <= thread_program_counter; // RQ19
		end else if (debug_write_active
			&& hits(status_addr, `OFFSET_SAVED_PROGRAM_COUNTER)) begin
			saved_program_counter <= status_wdata; // RQ24
		end
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			saved_stack_pointer <= '0;
		end else if (clock_enable && debug_entry) begin
			saved_stack_pointer <= thread_stack_pointer; // RQ20
		end else if (debug_write_active
			&& hits(status_addr, `OFFSET_SAVED_STACK_POINTER)) begin
			saved_stack_pointer <= status_wdata; // RQ24
		end
	end

	// ***********************************
	// register fetch operands
	// ***********************************
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			debug_fetch_thread_select <= '0;
			debug_fetch_register_select <= '0;
		end else if (debug_write_active) begin
			if (hits(status_addr, `OFFSET_DEBUG_FETCH_THREAD_SELECT)) begin
				debug_fetch_thread_select <=
					status_wdata[`DEBUG_THREAD_SELECT_WIDTH-1:0]; // RQ21
			end
			if (hits(status_addr, `OFFSET_DEBUG_FETCH_REGISTER_SELECT)) begin
				debug_fetch_register_select <=
					status_wdata[`DEBUG_REGISTER_SELECT_WIDTH-1:0]; // RQ22
			end
		end
	end

	assign debug_fetch_thread = debug_fetch_thread_select;
	assign debug_fetch_register = debug_fetch_register_select;

	// ***********************************
	// read mux
	// ***********************************
	always_comb begin
		next_rdata = '0;
		next_unmapped = 1'b0;
		case (status_addr)
			`OFFSET_SECURITY_CONFIG: next_rdata = security_config;
			`OFFSET_RING_OSC_CONTROL: begin
				next_rdata[`OSC_CORE_ENABLE_BIT] = ring_osc_control[1];
				next_rdata[`OSC_PERIPH_ENABLE_BIT] = ring_osc_control[0];
				next_rdata[`OSC_SETTLED_BIT] =
					(osc_phase == core_status_pkg::osc_settled);
			end
			`OFFSET_CORE_CELL_OSC_COUNT,
			`OFFSET_CORE_WIRE_OSC_COUNT,
			`OFFSET_PERIPH_CELL_OSC_COUNT,
			`OFFSET_PERIPH_WIRE_OSC_COUNT: begin
				next_rdata[OSC_WIDTH-1:0] = pick_count(
					2'(status_addr - `OFFSET_CORE_CELL_OSC_COUNT),
					osc_count[0], osc_count[1],
					osc_count[2], osc_count[3]); // RQ12 RQ13
			end
			`OFFSET_MEMORY_SIZE: next_rdata = MEMORY_BYTES & `MEMORY_SIZE_LOW_MASK; // RQ14
			`OFFSET_SAVED_STATUS_WORD: begin
				next_rdata[`STATUS_WORD_WIDTH-1:0] = saved_status_word;
			end
			`OFFSET_SAVED_PROGRAM_COUNTER: next_rdata = saved_program_counter;
			`OFFSET_SAVED_STACK_POINTER: next_rdata = saved_stack_pointer;
			`OFFSET_DEBUG_FETCH_THREAD_SELECT: begin
				next_rdata[`DEBUG_THREAD_SELECT_WIDTH-1:0] = debug_fetch_thread_select;
			end
			`OFFSET_DEBUG_FETCH_REGISTER_SELECT: begin
				next_rdata[`DEBUG_REGISTER_SELECT_WIDTH-1:0] =
					debug_fetch_register_select;
			end
			default: next_unmapped = 1'b1;
		endcase
	end

	// ***********************************
	// read answer
	// ***********************************
	// answer one cycle after the request; data held until the next read
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status_rdata <= '0;
			status_rvalid <= 1'b0;
			status_unmapped <= 1'b0;
		end else if (clock_enable) begin
			status_rvalid <= status_read; // RQ23
			if (status_read) begin
				status_rdata <= next_rdata;
			end
			if (status_read || status_write) begin
				status_unmapped <= next_unmapped
					|| (status_write && is_debug_field(status_addr) && !debug_mode); // RQ24
			end
		end
	end
endmodule
`default_nettype wire

// ---- test/status_core_model.sv ----
// processor core model issuing status reads and writes
`timescale 1ns/10ps
`default_nettype none
module status_core_model (
	input wire logic clock,
	output logic status_read,
	output logic status_write,
	output core_status_pkg::status_addr_type status_addr,
	output core_status_pkg::word_type status_wdata,
	input wire core_status_pkg::word_type status_rdata,
	input wire logic status_rvalid
);
	initial begin
		status_read = 1'b0;
		status_write = 1'b0;
		status_addr = 8'h00;
		status_wdata = 32'h0000_0000;
	end
	// one access per call: driven 1 ns after an edge, taken at the next edge
	task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic rvalid);
		@(posedge clock);
		#1;
		status_read = !wr;
		status_write = wr;
		status_addr = addr;
		status_wdata = wdata;
		@(posedge clock);
		#1;
		rvalid = status_rvalid;
		rdata = status_rdata;
		status_read = 1'b0;
		status_write = 1'b0;
		// released address and data lines never keep the old value
		status_addr = ~addr;
		status_wdata = ~wdata;
	endtask
endmodule
`default_nettype wire

// ---- test/core_status_security_debug_regs_properties.sv ----
// port checks for the status bank
`timescale 1ns/10ps
`default_nettype none
module core_status_security_debug_regs_properties #(
	parameter logic [31:0] MEMORY_BYTES = 32'h0004_0000
) (
	input wire logic clock,
	input wire logic clock_enable,
	input wire logic rst_n,
	input wire logic status_read,
	input wire logic status_write,
	input wire core_status_pkg::status_addr_type status_addr,
	input wire core_status_pkg::word_type status_wdata,
	input wire core_status_pkg::word_type status_rdata,
	input wire logic status_rvalid,
	input wire logic status_unmapped,
	input wire logic otp_word_valid,
	input wire logic global_debug_disable,
	input wire logic [3:0] otp_sector_lock,
	input wire logic boot_from_otp,
	input wire logic jtag_config_access_deny,
	input wire logic jtag_tap_disable,
	input wire logic core_osc_enable,
	input wire logic periph_osc_enable,
	input wire logic debug_mode,
	input wire logic debug_entry,
	input wire logic [10:0] thread_status_word,
	input wire core_status_pkg::word_type thread_program_counter,
	input wire core_status_pkg::word_type thread_stack_pointer
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	let rd_at(a) = clock_enable && status_read && !status_write && status_addr == a;
	// capture edge, then a plain read on the very next edge
	sequence capture_read(logic [7:0] a);
		clock_enable && debug_entry ##1 rd_at(a) && !debug_entry;
	endsequence
	a_read_answer_pulse: assert property (clock_enable && status_read |=> status_rvalid)
		else $error("read not answered next cycle");
	a_answer_needs_read: assert property (status_rvalid |-> $past(status_read))
		else $error("answer without a read");
	a_memory_size_value: assert property (rd_at(8'h0c) |=>
		status_rdata == (MEMORY_BYTES & 32'hffff_fffc)) else $error("memory size wrong");
	a_security_pins_match: assert property (rd_at(8'h05) && !otp_word_valid |=>
		{global_debug_disable, boot_from_otp, jtag_config_access_deny, jtag_tap_disable} ==
		{status_rdata[14], status_rdata[5], status_rdata[4], status_rdata[0]})
		else $error("security pins differ from register");
	a_sector_lock_map: assert property (rd_at(8'h05) && !otp_word_valid |=>
		otp_sector_lock == (status_rdata[11:8] | {4{status_rdata[12]}}))
		else $error("sector lock map wrong");
	a_osc_enable_write: assert property (clock_enable && status_write &&
		status_addr == 8'h06 |=> {30'h0, core_osc_enable, periph_osc_enable} ==
		($past(status_wdata) & 32'h3)) else $error("oscillator enables not written");
	a_count_upper_zero: assert property (clock_enable && status_read && !status_write &&
		status_addr inside {[8'h07:8'h0a]} |=> status_rdata[31:16] == 16'h0000)
		else $error("count upper bits set");
	a_capture_status: assert property (capture_read(8'h10) |=>
		(status_rdata & 32'hffff_fedf) == ({21'h0, $past(thread_status_word, 2)} & 32'h6df))
		else $error("status word not captured");
	a_capture_counter: assert property (capture_read(8'h11) |=>
		status_rdata == $past(thread_program_counter, 2)) else $error("counter not captured");
	a_capture_stack: assert property (capture_read(8'h12) |=>
		status_rdata == $past(thread_stack_pointer, 2)) else $error("stack not captured");
	a_debug_write_refused: assert property (clock_enable && status_write && !debug_mode &&
		status_addr inside {[8'h10:8'h14]} |=> status_unmapped)
		else $error("debug write outside debug mode not flagged");
	a_fetch_field_width: assert property (rd_at(8'h14) |=> status_rdata[31:5] == 27'h0)
		else $error("register select too wide");
endmodule
bind core_status_security_debug_regs core_status_security_debug_regs_properties #(
	.MEMORY_BYTES(MEMORY_BYTES)
) checker_inst (
	.clock, .clock_enable, .rst_n, .status_read, .status_write, .status_addr, .status_wdata,
	.status_rdata, .status_rvalid, .status_unmapped, .otp_word_valid, .global_debug_disable,
	.otp_sector_lock, .boot_from_otp, .jtag_config_access_deny, .jtag_tap_disable,
	.core_osc_enable, .periph_osc_enable, .debug_mode, .debug_entry, .thread_status_word,
	.thread_program_counter, .thread_stack_pointer
);
`default_nettype wire

// ---- test/core_status_security_debug_regs_bench.sv ----
// self-checking bench for the status bank
`timescale 1ns/10ps
`default_nettype none
module core_status_security_debug_regs_bench;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] data;
		logic [31:0] exp_data;
		logic unmapped;
	} row_type;
	logic clock = 1'b0, rst_n = 1'b0, otp_word_valid = 1'b0, debug_mode = 1'b1;
	logic debug_entry = 1'b0, status_read, status_write, status_rvalid, status_unmapped;
	logic global_debug_disable, otp_redundancy_enable, boot_from_otp, jtag_config_access_deny;
	logic jtag_tap_disable, core_osc_enable, periph_osc_enable, rvalid;
	logic [3:0] otp_sector_lock, ring_osc_in = 4'h0;
	logic [7:0] debug_fetch_thread;
	logic [4:0] debug_fetch_register;
	logic [10:0] thread_status_word = 11'h4df;
	core_status_pkg::status_addr_type status_addr;
	core_status_pkg::word_type status_wdata, status_rdata, rdata, otp_security_word = 32'h0;
	core_status_pkg::word_type thread_program_counter = 32'h1357_9bdf;
	core_status_pkg::word_type thread_stack_pointer = 32'h2468_ace0;
	core_status_pkg::word_type counts [4];
	int err_count = 0, num_checks = 0, cycles = 0;
	row_type rows [19];
	status_core_model core (.clock, .status_read, .status_write, .status_addr, .status_wdata,
		.status_rdata, .status_rvalid);
	core_status_security_debug_regs #(.MEMORY_BYTES(32'h0001_2347)) dut (.clock,
		.clock_enable(1'b1), .rst_n, .status_read, .status_write, .status_addr, .status_wdata,
		.status_rdata, .status_rvalid, .status_unmapped, .otp_word_valid, .otp_security_word,
		.global_debug_disable, .otp_sector_lock, .otp_redundancy_enable, .boot_from_otp,
		.jtag_config_access_deny, .jtag_tap_disable, .core_osc_enable, .periph_osc_enable,
		.ring_osc_in, .debug_mode, .debug_entry, .thread_status_word, .thread_program_counter,
		.thread_stack_pointer, .debug_fetch_thread, .debug_fetch_register);
	always #4 clock = ~clock;
	// oscillators free-run at rates unrelated to the core clock
	always #3.7 ring_osc_in[0] = ~ring_osc_in[0];
	always #5.9 ring_osc_in[1] = ~ring_osc_in[1];
	always #6.3 ring_osc_in[2] = ~ring_osc_in[2];
	always #9.1 ring_osc_in[3] = ~ring_osc_in[3];
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			close_out();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	function automatic logic [31:0] pins();
		return {23'h0, global_debug_disable, otp_sector_lock, otp_redundancy_enable,
			boot_from_otp, jtag_config_access_deny, jtag_tap_disable};
	endfunction
	task automatic load_otp(input logic [31:0] word);
		@(posedge clock);
		#1;
		otp_word_valid = 1'b1;
		otp_security_word = word;
		@(posedge clock);
		#1;
		otp_word_valid = 1'b0;
		otp_security_word = ~word;
		@(posedge clock);
		#1;
	endtask
	task automatic capture(input logic [7:0] addr, input logic [31:0] exp);
		debug_entry = 1'b1;
		fork
			core.access(1'b0, addr, 32'h0, rdata, rvalid);
			begin
				@(posedge clock);
				#1;
				debug_entry = 1'b0;
			end
		join
		check("captured value", exp, rdata);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rows = '{'{1, 8'h05, 32'hffff_ffff, 0, 0}, '{0, 8'h05, 0, 32'h8000_5fb1, 0},
			'{1, 8'h05, 0, 0, 0}, '{0, 8'h05, 0, 32'h8000_5fb1, 0}, '{1, 8'h06, 3, 0, 0},
			'{0, 8'h06, 0, 3, 0}, '{0, 8'h0c, 0, 32'h0001_2344, 0}, '{0, 8'h0b, 0, 0, 1},
			'{1, 8'h07, 32'hffff_ffff, 0, 0}, '{1, 8'h10, 32'hffff_ffff, 0, 0},
			'{0, 8'h10, 0, 32'h6df, 0}, '{1, 8'h11, 32'hdead_beef, 0, 0},
			'{0, 8'h11, 0, 32'hdead_beef, 0}, '{1, 8'h12, 32'h1234_5678, 0, 0},
			'{0, 8'h12, 0, 32'h1234_5678, 0}, '{1, 8'h13, 32'hffff_ffff, 0, 0},
			'{0, 8'h13, 0, 32'hff, 0}, '{1, 8'h14, 32'hffff_ffff, 0, 0},
			'{0, 8'h14, 0, 32'h1f, 0}};
		repeat (5) @(posedge clock);
		#1;
		check("reset pins", 32'h0, pins() | {30'h0, core_osc_enable, periph_osc_enable});
		rst_n = 1'b1;
		repeat (2) @(posedge clock);
		load_otp(32'h0000_42b1);
		check("loaded pins", 32'h12f, pins());
		load_otp(32'h0);
		check("second load ignored", 32'h12f, pins());
		$display("test reset and load done");
		for (int i = 0; i < 19; i++) begin
			core.access(rows[i].wr, rows[i].addr, rows[i].data, rdata, rvalid);
			if (!rows[i].wr) begin
				check("answer", 32'h1, {31'h0, rvalid});
				check("read data", rows[i].exp_data, rdata);
			end
			check("unmapped", {31'h0, rows[i].unmapped}, {31'h0, status_unmapped});
		end
		check("fetch selects", 32'h0000_1fff, {19'h0, debug_fetch_thread, debug_fetch_register});
		$display("test register table done");
		debug_mode = 1'b0;
		core.access(1'b1, 8'h13, 32'h0, rdata, rvalid);
		check("refused flag", 32'h1, {31'h0, status_unmapped});
		core.access(1'b0, 8'h13, 32'h0, rdata, rvalid);
		check("refused write kept", 32'hff, rdata);
		capture(8'h10, 32'h4df);
		capture(8'h11, 32'h1357_9bdf);
		capture(8'h12, 32'h2468_ace0);
		$display("test debug capture done");
		core.access(1'b1, 8'h06, 32'h0, rdata, rvalid);
		repeat (12) @(posedge clock);
		core.access(1'b0, 8'h06, 32'h0, rdata, rvalid);
		check("settled control", 32'h4, rdata);
		for (int i = 0; i < 4; i++) begin
			core.access(1'b0, 8'h07 + 8'(i), 32'h0, counts[i], rvalid);
			core.access(1'b0, 8'h07 + 8'(i), 32'h0, rdata, rvalid);
			check("stopped count", counts[i], rdata);
		end
		$display("test oscillators done");
		@(posedge clock) #1 rst_n = 1'b0;
		@(posedge clock) #1 check("pins in second reset", 32'h0, pins());
		rst_n = 1'b1;
		repeat (2) @(posedge clock);
		load_otp(32'h0000_1100);
		check("reloaded pins", 32'h0f0, pins());
		core.access(1'b1, 8'h05, 32'h1, rdata, rvalid);
		core.access(1'b0, 8'h05, 32'h0, rdata, rvalid);
		check("lock cleared by reset", 32'h1, rdata);
		for (int i = 0; i < 4; i++) begin
			core.access(1'b0, 8'h07 + 8'(i), 32'h0, rdata, rvalid);
			check("count kept over reset", counts[i], rdata);
		end
		$display("test second reset done");
		close_out();
	end
endmodule
`default_nettype wire
